// ==== hw/tsc_pkg.sv ====
// Notes on behaviour
// RULE1: with the enable bit clear, all other settings are ignored and nothing is acquired.
// RULE2: software writes start to 1; hardware clears it when acquisition completes.
// RULE3: mode bit 2 picks normal (0) or synchronous (1) acquisition.
// RULE4: polarity bit 3: 0 falling edge only, 1 rising edge and high level.
// RULE5: idle bit 4: unused pins driven low (0) or left floating (1).
// RULE6: bits 7:5 pick pulse limit 255 up to 16383; code 111 reserved.
// RULE7: bits 14:12 divide the bus clock by two to the field value.
// RULE8: bit 15 gives spread clock as bus clock or bus clock over two.
// RULE9: bit 16 turns spread spectrum variation of charge pulses on.
// RULE10: bits 23:17 bound spread periods added to high phase, 1 to 128.
// RULE11: bits 27:24 give low phase of field plus one pulse clock periods.
// RULE12: bits 31:28 give high phase of field plus one pulse clock periods.
// RULE13: software keeps configuration unchanged while acquisition runs.
// RULE14: irq enable bit 0 lets the done flag raise the interrupt.
// RULE15: irq enable bit 1 lets the overcount flag raise the interrupt.
// RULE16: writing 1 to clear bit 0 clears the done flag; 0 does nothing.
// RULE17: writing 1 to clear bit 1 clears the overcount flag; 0 does nothing.
// RULE18: on pulse limit, stop transfer at once, set overcount and done flags.
// RULE19: done flag sets once every enabled group has reached threshold.
// RULE20: in synchronous mode, transfer waits for the chosen sync edge or level.
// RULE21: interrupt output is high while any enabled flag is set.
package tsc_pkg;
  localparam logic [7:0]  TOUCH_CONTROL_OFS   = 8'h00;
  localparam logic [7:0]  TSC_IRQEN_OFS  = 8'h04;
  localparam logic [7:0]  TSC_FCLR_OFS   = 8'h08;
  localparam logic [7:0]  TSC_STAT_OFS   = 8'h0C;
  localparam logic [31:0] TOUCH_CONTROL_RST   = 32'h0000_0000;
  localparam logic [1:0]  TSC_IRQEN_RST  = 2'h0;
  localparam int          TSC_EN_BIT     = 0;
  localparam int          TSC_START_BIT  = 1;
  localparam int          TSC_MODE_BIT   = 2;
  localparam int          TSC_POL_BIT    = 3;
  localparam int          TSC_IDLE_BIT   = 4;
  localparam int          TSC_MAX_LSB    = 5;
  localparam int          TSC_PGDIV_LSB  = 12;
  localparam int          TSC_SSDIV_BIT  = 15;
  localparam int          TSC_SPREAD_ENABLE_BIT   = 16;
  localparam int          TSC_SSDEV_LSB  = 17;
  localparam int          TSC_LOW_LSB    = 24;
  localparam int          TSC_HIGH_LSB   = 28;
  localparam int          TSC_DONE_BIT   = 0;
  localparam int          TSC_OVER_BIT   = 1;
  localparam int          TSC_CNT_W      = 14;
  localparam logic [2:0]  TSC_MAX_RSVD   = 3'h7;
  localparam logic [6:0]  TSC_LFSR_SEED  = 7'h5A;
  typedef enum logic [2:0] {
    TSC_IDLE   = 3'h0,
    TSC_WAIT   = 3'h1,
    TSC_HIGH   = 3'h3,
    TSC_SPREAD = 3'h7,
    TSC_LOW    = 3'h5,
    TSC_DONE   = 3'h4
  } tsc_state_t;
endpackage

// ==== hw/touch_control.sv ====
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module touch_control
  import tsc_pkg::*;
#(
  parameter int GROUPS = 8
) (
  input  wire logic                     clk,           // 100 MHz bus clock
  input  wire logic                     rst,           // synchronous reset
  input  wire logic [7:0]               addr,          // byte address
  input  wire logic [31:0]              wr_data,       // write data
  input  wire logic                     wr_en,         // write strobe
  input  wire logic                     rd_en,         // read strobe
  output logic      [31:0]              rd_data,       // read data, cycle after strobe
  input  wire logic [GROUPS-1:0]        group_en,      // enabled groups, same clock
  input  wire logic [GROUPS-1:0]        sample_in,     // sampling pins, async
  input  wire logic                     sync_in,       // sync pin, async
  output logic                          charge_out,    // charge pulse high phase
  output logic                          xfer_out,      // low phase, switch closed
  output logic                          idle_oe,       // idle pins driven low
  output logic      [GROUPS-1:0]        group_done,    // group reached threshold
  output logic      [GROUPS*TSC_CNT_W-1:0] group_count, // latched pulse counts
  output logic                          irq            // interrupt request
);
  logic [31:0]           ctrl;
  logic [1:0]            irq_en;
  logic                  done_flag;
  logic                  over_flag;
  tsc_state_t            state;
  tsc_state_t            next_state;
  logic [6:0]            pre_cnt;
  logic [3:0]            ph_cnt;
  logic [7:0]            ss_cnt;
  logic                  ss_ph;
  logic [6:0]            lfsr;
  logic [TSC_CNT_W-1:0]  pulse_cnt;
  logic [GROUPS-1:0]     samp_m;
  logic [GROUPS-1:0]     samp_s;
  logic                  sync_m;
  logic                  sync_s;
  logic                  sync_d;

  // field views
  wire       enable   = ctrl[TSC_EN_BIT];
  wire       start    = ctrl[TSC_START_BIT];
  wire       mode     = ctrl[TSC_MODE_BIT];
  wire       pol      = ctrl[TSC_POL_BIT];
  wire       idle_md  = ctrl[TSC_IDLE_BIT];
  wire [2:0] max_sel  = ctrl[TSC_MAX_LSB +: 3];
  wire [2:0] pg_div   = ctrl[TSC_PGDIV_LSB +: 3];
  wire       ss_div   = ctrl[TSC_SSDIV_BIT];
  wire       ss_en    = ctrl[TSC_SPREAD_ENABLE_BIT];
  wire [6:0] ss_dev   = ctrl[TSC_SSDEV_LSB +: 7];
  wire [3:0] low_len  = ctrl[TSC_LOW_LSB +: 4];
  wire [3:0] high_len = ctrl[TSC_HIGH_LSB +: 4];

  // address decode
  wire sel_ctrl  = (addr == TOUCH_CONTROL_OFS);
  wire sel_irqen = (addr == TSC_IRQEN_OFS);
  wire sel_fclr  = (addr == TSC_FCLR_OFS);
  wire sel_stat  = (addr == TSC_STAT_OFS);
  wire wr_ctrl   = wr_en && sel_ctrl;
  wire wr_irqen  = wr_en && sel_irqen;
  wire clr_done  = wr_en && sel_fclr && wr_data[TSC_DONE_BIT];  // RULE16
  wire clr_over  = wr_en && sel_fclr && wr_data[TSC_OVER_BIT];  // RULE17

  logic [31:0] rd_mux;
  assign rd_mux = sel_ctrl  ? ctrl :
                  sel_irqen ? {30'h0, irq_en} :
                  sel_stat  ? {30'h0, over_flag, done_flag} :
                  32'h0;

  // pulse generator clock: tick when the low div bits are all ones
  wire [6:0] pg_mask = 7'(({7'h0, 1'b1} << pg_div) - 8'h01);
  wire       pg_tick = ((pre_cnt & pg_mask) == pg_mask);          // RULE7
  wire       ss_tick = ss_div ? ss_ph : 1'b1;                     // RULE8

  // pulse limit; reserved code is held at the largest limit
  wire [2:0] max_eff = (max_sel == TSC_MAX_RSVD) ? 3'h6 : max_sel;
  wire [TSC_CNT_W-1:0] max_cnt =
    TSC_CNT_W'((15'h0100 << max_eff) - 15'h0001);                  // RULE6

  // extra high-phase periods: pseudo-random, 1 up to deviation+1
  wire [7:0] ss_extra = {1'b0, lfsr & ss_dev} + 8'h01;             // RULE10

  // sync trigger; sync_s and sync_d are second stage and later
  wire sync_hit = pol ? sync_s : (sync_d && !sync_s);             // RULE4

  wire [GROUPS-1:0] reach   = samp_s & group_en & ~group_done;
  wire [GROUPS-1:0] done_nx = group_done | reach;
  wire all_done = ((done_nx & group_en) == group_en);              // RULE19
  // the pulse now ending is counted, so the limit is the number of pulses run
  wire at_limit = ((pulse_cnt + TSC_CNT_W'(1)) == max_cnt);
  wire hi_end   = pg_tick && (ph_cnt == high_len);                 // RULE12
  wire lo_end   = pg_tick && (ph_cnt == low_len);                  // RULE11
  wire ss_end   = ss_tick && (ss_cnt == ss_extra - 8'h01);
  wire in_low   = (state == TSC_LOW);
  wire finish_ok   = in_low && lo_end && all_done;
  wire finish_over = in_low && lo_end && !all_done && at_limit;    // RULE18
  wire launch   = (state == TSC_IDLE) && enable && start;          // RULE2

  always_comb begin
    next_state = state;
    case (state)
      TSC_IDLE: begin
        if (launch) begin
          next_state = mode ? TSC_WAIT : TSC_HIGH;                 // RULE3
        end
      end
      TSC_WAIT: begin
        if (sync_hit) begin
          next_state = TSC_HIGH;                                   // RULE20
        end
      end
      TSC_HIGH: begin
        if (hi_end) begin
          next_state = ss_en ? TSC_SPREAD : TSC_LOW;               // RULE9
        end
      end
      TSC_SPREAD: begin
        if (ss_end) begin
          next_state = TSC_LOW;
        end
      end
      TSC_LOW: begin
        if (finish_ok || finish_over) begin
          next_state = TSC_DONE;
        end else if (lo_end) begin
          next_state = TSC_HIGH;
        end
      end
      TSC_DONE: begin
        next_state = TSC_IDLE;
      end
      default: begin
        next_state = TSC_IDLE;
      end
    endcase
    if (!enable) begin
      next_state = TSC_IDLE;                                       // RULE1
    end
  end

  // pin synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      samp_m <= '0;
      samp_s <= '0;
      sync_m <= 1'b0;
      sync_s <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      samp_m <= sample_in;
      samp_s <= samp_m;
      sync_m <= sync_in;
      sync_s <= sync_m;
      sync_d <= sync_s;
    end
  end

  // register file; a write of start in the done cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= TOUCH_CONTROL_RST;
    end else begin
      if (state == TSC_DONE) begin
        ctrl[TSC_START_BIT] <= 1'b0;                               // RULE2
      end
      if (wr_ctrl) begin
        ctrl <= wr_data & 32'hFFFF_F0FF;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en <= TSC_IRQEN_RST;
    end else if (wr_irqen) begin
      irq_en <= wr_data[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 32'h0;
    end else begin
      rd_data <= rd_en ? rd_mux : 32'h0;
    end
  end

  // flags: a hardware set beats a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      done_flag <= 1'b0;
      over_flag <= 1'b0;
    end else begin
      done_flag <= (finish_ok || finish_over) || (done_flag && !clr_done);  // RULE18
      over_flag <= finish_over || (over_flag && !clr_over);                 // RULE18
    end
  end

  // interrupt follows the flags one cycle late
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (done_flag && irq_en[TSC_DONE_BIT])                            // RULE14
          || (over_flag && irq_en[TSC_OVER_BIT]);                           // RULE15 RULE21
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= TSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // prescaler runs only in the timed phases, so every phase starts aligned
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt <= 7'h0;
    end else begin
      pre_cnt <= (state == TSC_HIGH || state == TSC_LOW) ? pre_cnt + 7'h01 : 7'h0;
    end
  end

  // spread clock has its own phase bit: the prescaler is parked during spread
  always_ff @(posedge clk) begin
    if (rst) begin
      ss_cnt <= 8'h0;
      ss_ph  <= 1'b0;
    end else if (state == TSC_SPREAD) begin
      ss_cnt <= ss_tick ? ss_cnt + 8'h01 : ss_cnt;
      ss_ph  <= !ss_ph;
    end else begin
      ss_cnt <= 8'h0;
      ss_ph  <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ph_cnt <= 4'h0;
    end else if (next_state != state) begin
      ph_cnt <= 4'h0;
    end else if (pg_tick) begin
      ph_cnt <= ph_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr <= TSC_LFSR_SEED;
    end else if (ss_end) begin
      lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_cnt <= '0;
    end else if (launch) begin
      pulse_cnt <= '0;
    end else if (in_low && lo_end) begin
      pulse_cnt <= pulse_cnt + 1'b1;
    end
  end

  // group results
  always_ff @(posedge clk) begin
    if (rst) begin
      group_done  <= '0;
      group_count <= '0;
    end else begin
      if (launch) begin
        group_done <= '0;
      end else if (in_low && !finish_over) begin
        // an overrun leaves unfinished groups unmarked
        group_done <= done_nx;
      end
      for (int g = 0; g < GROUPS; g++) begin
        if (in_low && reach[g] && !finish_over) begin
          group_count[g*TSC_CNT_W +: TSC_CNT_W] <= pulse_cnt + 1'b1;
        end
      end
    end
  end

  // charge and transfer pins follow the next state so they line up with the phase counters; idle_oe follows the enable and idle bits
  always_ff @(posedge clk) begin
    if (rst) begin
      charge_out <= 1'b0;
      xfer_out   <= 1'b0;
      idle_oe    <= 1'b0;
    end else begin
      charge_out <= (next_state == TSC_HIGH) || (next_state == TSC_SPREAD);
      xfer_out   <= (next_state == TSC_LOW);
      idle_oe    <= enable && !idle_md;                            // RULE5
    end
  end
endmodule
`default_nettype wire

// ==== tb/touch_control_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module touch_control_sva
  import tsc_pkg::*;
#(
  parameter int GROUPS = 8
) (
  input wire logic                        clk,         // clock
  input wire logic                        rst,         // reset
  input wire logic [7:0]                  addr,        // address
  input wire logic [31:0]                 wr_data,     // write data
  input wire logic                        wr_en,       // write
  input wire logic                        rd_en,       // read
  input wire logic [31:0]                 rd_data,     // read data
  input wire logic [GROUPS-1:0]           group_en,    // groups
  input wire logic [GROUPS-1:0]           sample_in,   // samples
  input wire logic                        sync_in,     // sync
  input wire logic                        charge_out,  // high phase
  input wire logic                        xfer_out,    // low phase
  input wire logic                        idle_oe,     // idle drive
  input wire logic [GROUPS-1:0]           group_done,  // reached
  input wire logic [GROUPS*TSC_CNT_W-1:0] group_count, // counts
  input wire logic                        irq          // interrupt
);
  logic [31:0] ctl;
  logic [1:0]  ien;
  logic [11:0] hcnt;
  logic [11:0] lcnt;
  wire  [11:0] hbase = ({8'h00, ctl[31:28]} + 12'h001) << ctl[14:12];
  wire  [11:0] lbase = ({8'h00, ctl[27:24]} + 12'h001) << ctl[14:12];
  wire  [11:0] sper  = ctl[15] ? 12'h002 : 12'h001;
  // one clock of slack; the spread clock phase bit restarts at zero on every entry to spread
  wire  [11:0] hmax  = hbase + sper * ({5'h00, ctl[23:17]} + 12'h001) + 12'h001;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl <= 32'h0;
      ien <= 2'h0;
    end else if (wr_en && addr == TOUCH_CONTROL_OFS) begin
      ctl <= wr_data;
    end else if (wr_en && addr == TSC_IRQEN_OFS) begin
      ien <= wr_data[1:0];
    end
  end
  always_ff @(posedge clk) begin
    hcnt <= charge_out ? hcnt + 12'h001 : 12'h000;
    lcnt <= xfer_out ? lcnt + 12'h001 : 12'h000;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_DISABLED_QUIET: assert property ((!ctl[0])[*3] |-> !charge_out && !xfer_out)
    else $error("pulses while disabled");
  AST_IDLE_LOW: assert property ((ctl[0] && !ctl[4])[*2] |-> idle_oe)
    else $error("idle pins not driven");
  AST_IDLE_FLOAT: assert property ((!ctl[0] || ctl[4])[*2] |-> !idle_oe)
    else $error("idle pins driven");
  AST_PHASE_EXCL: assert property (!(charge_out && xfer_out))
    else $error("both phases high");
  AST_HIGH_LEN: assert property ($fell(charge_out) && !ctl[16] |-> hcnt == hbase)
    else $error("high phase length");
  AST_LOW_LEN: assert property ($fell(xfer_out) |-> lcnt == lbase)
    else $error("low phase length");
  AST_SPREAD_LEN: assert property ($fell(charge_out) && ctl[16] |-> hcnt > hbase && hcnt <= hmax)
    else $error("spread high length");
  AST_IRQ_MASKED: assert property ((ien == 2'h0)[*2] |-> !irq)
    else $error("irq while masked");
  AST_FCLR_READ: assert property (rd_en && addr == TSC_FCLR_OFS |=> rd_data == 32'h0)
    else $error("clear register reads nonzero");
endmodule
bind touch_control touch_control_sva #(.GROUPS(GROUPS)) touch_control_sva_inst (
  .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .group_en(group_en), .sample_in(sample_in), .sync_in(sync_in),
  .charge_out(charge_out), .xfer_out(xfer_out), .idle_oe(idle_oe),
  .group_done(group_done), .group_count(group_count), .irq(irq));
`default_nettype wire

// ==== tb/tsc_electrode_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module tsc_electrode_model #(
  parameter int GROUPS = 8
) (
  input  wire logic                clk,       // clock
  input  wire logic                dis,       // discharge caps
  input  wire logic                xfer_out,  // transfer phase
  input  wire logic [GROUPS*8-1:0] thr,       // transfers to threshold, 0 never
  output logic      [GROUPS-1:0]   sample_in  // threshold reached
);
  logic [7:0] cnt [GROUPS];
  logic       xq;
  always_ff @(posedge clk) begin
    xq <= xfer_out;
    for (int g = 0; g < GROUPS; g++) begin
      if (dis) cnt[g] <= 8'h00;
      else if (xfer_out && !xq && cnt[g] != 8'hFF) cnt[g] <= cnt[g] + 8'h01;
    end
  end
  // cap voltage crosses during the transfer that reaches the count
  always_comb begin
    for (int g = 0; g < GROUPS; g++) sample_in[g] = thr[g*8 +: 8] != 8'h00 && cnt[g] >= thr[g*8 +: 8];
  end
endmodule
`default_nettype wire

// ==== tb/touch_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module touch_control_tb
  import tsc_pkg::*;
;
  localparam int G = 8;
  logic clk, rst, wr_en, rd_en, sync_in, charge_out, xfer_out, idle_oe, irq, dis, pch;
  logic [7:0]             addr;
  logic [31:0]            wr_data, rd_data, got, c;
  logic [G-1:0]           group_en, sample_in, group_done;
  logic [G*TSC_CNT_W-1:0] group_count;
  logic [G*8-1:0]         thr;
  int npulse = 0;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 83305;
  touch_control #(.GROUPS(G)) touch_control_inst (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .group_en(group_en), .sample_in(sample_in), .sync_in(sync_in),
    .charge_out(charge_out), .xfer_out(xfer_out), .idle_oe(idle_oe),
    .group_done(group_done), .group_count(group_count), .irq(irq));
  tsc_electrode_model #(.GROUPS(G)) tsc_electrode_model_inst (
    .clk(clk), .dis(dis), .xfer_out(xfer_out), .thr(thr), .sample_in(sample_in));
  function automatic logic [31:0] limit(input int m);
    return (32'h100 << m) - 32'h1;
  endfunction
  function automatic logic [31:0] ctl_rd(input logic [31:0] d);
    return d & 32'hFFFF_F0FF;
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    checks_done++;
    if (v !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, v);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    got = rd_data;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, got);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 40000; i++) begin
      rd(TSC_STAT_OFS);
      if (got[0] === 1'b1) return;
    end
    chk("acquisition end", 32'h1, got);
    conclude();
  endtask
  // caps are emptied before each run so counts start from zero
  task automatic launch(input logic [31:0] cv);
    @(posedge clk);
    dis <= 1'b1;
    @(posedge clk);
    dis <= 1'b0;
    wr(TOUCH_CONTROL_OFS, cv);
  endtask
  always @(posedge clk) begin
    pch <= charge_out;
    if (dis) npulse <= 0;
    else if (charge_out && !pch) npulse <= npulse + 1;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, dis} <= 2'b11;
    {wr_en, rd_en, sync_in} <= 3'b000;
    {addr, wr_data, group_en, thr} <= '0;
    repeat (10) @(posedge clk);
    {rst, dis} <= 2'b00;
    for (int a = 0; a < 20; a += 4) rdc(8'(a), 32'h0, "reset value");
    c = $random(seed) & 32'hFFFF_FFFE;
    wr(TOUCH_CONTROL_OFS, c);
    wr(TSC_IRQEN_OFS, c);
    wr(8'h10, c);
    repeat (20) @(posedge clk);
    rdc(TOUCH_CONTROL_OFS, ctl_rd(c), "control");
    rdc(TSC_IRQEN_OFS, c & 32'h3, "irq enable");
    rdc(8'h10, 32'h0, "unmapped");
    rdc(TSC_STAT_OFS, 32'h0, "status");
    chk("pulses", 32'h0, npulse);
    wr(TSC_IRQEN_OFS, 32'h0);
    for (int k = 0; k < 3; k++) begin
      group_en <= G'($random(seed)) | G'(1);
      for (int g = 0; g < G; g++) thr[g*8 +: 8] <= 8'(($random(seed) & 15) + 1);
      c = ($random(seed) & 32'hFCFF_9010) | 32'h0300_0003;
      launch(c);
      wait_done();
      chk("status", 32'h1, got);
      rdc(TOUCH_CONTROL_OFS, ctl_rd(c) & ~32'h2, "start bit");
      for (int g = 0; g < G; g++) if (group_en[g]) chk("count", 32'(thr[g*8 +: 8]), 32'(group_count[g*TSC_CNT_W +: TSC_CNT_W]));
      chk("group done", 32'(group_en), 32'(group_done & group_en));
      wr(TSC_FCLR_OFS, 32'h1);
      rdc(TSC_STAT_OFS, 32'h0, "cleared");
    end
    thr <= '0;
    for (int m = 0; m < 7; m++) begin
      launch(32'h3 | (32'(m) << TSC_MAX_LSB));
      wait_done();
      chk("status", 32'h3, got);
      chk("pulses", limit(m), npulse);
      if (m < 6) wr(TSC_FCLR_OFS, 32'h3);
    end
    rdc(TOUCH_CONTROL_OFS, 32'hC1, "start bit");
    wr(TSC_IRQEN_OFS, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, 32'(irq));
    wr(TSC_FCLR_OFS, 32'h0);
    rdc(TSC_STAT_OFS, 32'h3, "status");
    wr(TSC_FCLR_OFS, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, 32'(irq));
    wr(TSC_IRQEN_OFS, 32'h2);
    rdc(TSC_STAT_OFS, 32'h2, "status");
    chk("irq", 32'h1, 32'(irq));
    wr(TSC_FCLR_OFS, 32'h2);
    rdc(TSC_STAT_OFS, 32'h0, "status");
    chk("irq", 32'h0, 32'(irq));
    for (int p = 0; p < 2; p++) begin
      sync_in <= (p == 0);
      launch(p == 1 ? 32'h0F : 32'h07);
      repeat (30) @(posedge clk);
      chk("sync hold", 32'h0, npulse);
      sync_in <= (p == 1);
      repeat (10) @(posedge clk);
      chk("sync run", 32'h1, 32'(npulse > 0));
      wait_done();
      wr(TSC_FCLR_OFS, 32'h3);
    end
    conclude();
  end
endmodule
`default_nettype wire
